// >>> pdf_port.sv
// Event flag register and token FIFO port behind a two-wire serial slave
`timescale 1ns/1ps
`default_nettype none

module pdf_port
    import pdf_pkg::*;
#(
    parameter int DEPTH = 16
)(
    input wire logic mclk, // System clock
    input wire logic rst_b, // Asynchronous reset
    input wire logic scl, // Serial clock pin
    input wire logic sda_i, // Serial data pin level
    output logic sda_o, // Serial data drive value
    output logic sda_oe_b, // Serial data enable, low drives
    input wire logic vbus_ok, // Supply above threshold
    input wire logic cc_activity, // Line activity present
    input wire logic comp_high, // Line above reference
    input wire logic wake_det, // Attach voltage seen
    input wire logic [1:0] bc_lvl, // Advertised current level
    input wire logic crc_checked, // Checksum result newly valid
    input wire logic [7:0] rx_data, // Receive queue head
    input wire logic rx_empty, // Receive queue empty
    input wire logic rx_full, // Receive queue full
    output logic rx_pop, // Receive queue pop
    output pdf_sym_e sym_kind, // Line symbol to send
    output logic [7:0] sym_data, // Packed byte for data symbol
    output logic sym_valid, // Symbol offered
    input wire logic sym_ready, // Symbol accepted
    output logic tx_drive, // Transmit driver on
    output logic txq_full, // Transmit queue full
    output logic txq_empty // Transmit queue empty
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;
        logic [5:0] lv_m, lv_s, lv_d;
        logic [7:0] flags;
        logic full_d;
        pdf_i2c_e ist;
        logic [2:0] bitc;
        logic [7:0] shr;
        logic [7:0] ptr;
        logic ptr_set, rw, ack_on, more, oe_b, pop;
        logic [DEPTH-1:0][7:0] mem;
        logic [AW-1:0] wp, rp;
        logic [AW:0] cnt;
        pdf_tx_e tst;
        logic [4:0] left;
        pdf_sym_e kind;
        logic [7:0] data;
        logic valid, drive;
    } pdf_state_s;

    pdf_state_s st_r;
    pdf_state_s st_nxt;
    logic rise, fall, start, stop, full_any, push, qpop, go, clr;
    logic [7:0] set_vec, byte_in, rdval, tok;
    logic [5:0] lv_chg;

    ////////////////////////////////////////////////////////////////////
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.pop = 1'b0;
        push = 1'b0;
        qpop = 1'b0;
        go = 1'b0;
        clr = 1'b0;
        set_vec = 8'h00;
        st_nxt.scl_m = scl;
        st_nxt.scl_s = st_r.scl_m;
        st_nxt.scl_d = st_r.scl_s;
        st_nxt.sda_m = sda_i;
        st_nxt.sda_s = st_r.sda_m;
        st_nxt.sda_d = st_r.sda_s;
        st_nxt.lv_m = {vbus_ok, cc_activity, comp_high, wake_det, bc_lvl};
        st_nxt.lv_s = st_r.lv_m;
        st_nxt.lv_d = st_r.lv_s;
        rise = st_r.scl_s & ~st_r.scl_d;
        fall = ~st_r.scl_s & st_r.scl_d;
        start = st_r.scl_s & st_r.scl_d & st_r.sda_d & ~st_r.sda_s;
        stop = st_r.scl_s & st_r.scl_d & ~st_r.sda_d & st_r.sda_s;
        byte_in = {st_r.shr[6:0], st_r.sda_s};
        tok = st_r.mem[st_r.rp];
        full_any = txq_full | rx_full;
        case (st_r.ptr)
            PDF_REG_FLAGS: rdval = st_r.flags;
            PDF_REG_FIFO: rdval = rx_data;
            default: rdval = 8'h00;
        endcase
        // Serial slave
        if (start)
        begin
            st_nxt.ist = I2C_ADDR;
            st_nxt.bitc = 3'h0;
            st_nxt.ptr_set = 1'b0;
            st_nxt.ack_on = 1'b0;
            st_nxt.oe_b = 1'b1;
        end
        else if (stop)
        begin
            st_nxt.ist = I2C_IDLE;
            st_nxt.oe_b = 1'b1;
        end
        else
        begin
            case (st_r.ist)
                I2C_ADDR, I2C_WBYTE:
                    if (rise)
                    begin
                        st_nxt.shr = byte_in;
                        st_nxt.bitc = st_r.bitc + 3'h1;
                        if (st_r.bitc == 3'h7)
                        begin
                            st_nxt.ist = I2C_ACK;
                            if (st_r.ist == I2C_ADDR)
                            begin
                                st_nxt.rw = byte_in[0];
                                if (byte_in[7:1] != PDF_BUS_ADDR)
                                    st_nxt.ist = I2C_IDLE;
                            end
                            else if (!st_r.ptr_set)
                            begin
                                st_nxt.ptr = byte_in;
                                st_nxt.ptr_set = 1'b1;
                            end
                            else if (st_r.ptr == PDF_REG_FIFO)
                            begin
                                if (byte_in == PDF_TOK_GO)
                                    go = 1'b1;
                                else
                                    push = ~txq_full;
                            end
                            else
                                st_nxt.ptr = st_r.ptr + 8'h01;
                        end
                    end
                I2C_ACK:
                    if (fall)
                    begin
                        st_nxt.ack_on = ~st_r.ack_on;
                        st_nxt.oe_b = st_r.ack_on;
                        st_nxt.bitc = 3'h0;
                        if (st_r.ack_on)
                            st_nxt.ist = st_r.rw ? I2C_RBYTE : I2C_WBYTE;
                        if (st_r.ack_on && st_r.rw)
                        begin
                            st_nxt.shr = rdval;
                            st_nxt.oe_b = rdval[7];
                            clr = (st_r.ptr == PDF_REG_FLAGS);
                            st_nxt.pop = (st_r.ptr == PDF_REG_FIFO) & ~rx_empty;
                            if (st_r.ptr != PDF_REG_FIFO)
                                st_nxt.ptr = st_r.ptr + 8'h01;
                        end
                    end
                I2C_RBYTE:
                    if (fall)
                    begin
                        st_nxt.bitc = st_r.bitc + 3'h1;
                        st_nxt.shr = {st_r.shr[6:0], 1'b0};
                        st_nxt.oe_b = st_r.shr[6];
                        if (st_r.bitc == 3'h7)
                        begin
                            st_nxt.oe_b = 1'b1;
                            st_nxt.ist = I2C_RACK;
                        end
                    end
                I2C_RACK:
                    if (rise)
                        st_nxt.more = ~st_r.sda_s;
                    else if (fall)
                    begin
                        st_nxt.ist = st_r.more ? I2C_RBYTE : I2C_IDLE;
                        st_nxt.bitc = 3'h0;
                        if (st_r.more)
                        begin
                            st_nxt.shr = rdval;
                            st_nxt.oe_b = rdval[7];
                            clr = (st_r.ptr == PDF_REG_FLAGS);
                            st_nxt.pop = (st_r.ptr == PDF_REG_FIFO) & ~rx_empty;
                            if (st_r.ptr != PDF_REG_FIFO)
                                st_nxt.ptr = st_r.ptr + 8'h01;
                        end
                    end
                default:
                    st_nxt.oe_b = 1'b1;
            endcase
        end
        ////////////////////////////////////////////////////////////////
        // Token engine; the receive path is untouched by a collision
        case (st_r.tst)
            TX_IDLE:
                if (go)
                begin
                    if (st_r.lv_s[PDF_LV_ACT])
                        set_vec[PDF_F_COLLIDE] = 1'b1;
                    else
                    begin
                        st_nxt.tst = TX_FETCH;
                        st_nxt.drive = 1'b1;
                    end
                end
            TX_FETCH:
                if (txq_empty)
                begin
                    st_nxt.tst = TX_IDLE;
                    st_nxt.drive = 1'b0;
                end
                else
                begin
                    qpop = 1'b1;
                    st_nxt.valid = 1'b1;
                    st_nxt.tst = TX_EMIT;
                    case (tok)
                        PDF_TOK_SYNC1: st_nxt.kind = SYM_SYNC1;
                        PDF_TOK_SYNC2: st_nxt.kind = SYM_SYNC2;
                        PDF_TOK_SYNC3: st_nxt.kind = SYM_SYNC3;
                        PDF_TOK_RST1: st_nxt.kind = SYM_RST1;
                        PDF_TOK_RST2: st_nxt.kind = SYM_RST2;
                        PDF_TOK_EOP: st_nxt.kind = SYM_EOP;
                        PDF_TOK_CRC: st_nxt.kind = SYM_CRC;
                        PDF_TOK_OFF:
                        begin
                            st_nxt.valid = 1'b0;
                            st_nxt.drive = 1'b0;
                            st_nxt.tst = TX_IDLE;
                        end
                        default:
                        begin
                            st_nxt.valid = 1'b0;
                            st_nxt.tst = TX_FETCH;
                            if (tok[7:5] == PDF_TOK_PACK_TAG && tok[4:0] >= PDF_PACK_MIN
                                && tok[4:0] <= PDF_PACK_MAX)
                            begin
                                st_nxt.left = tok[4:0];
                                st_nxt.tst = TX_PACK;
                            end
                        end
                    endcase
                end
            TX_PACK:
                if (!txq_empty)
                begin
                    qpop = 1'b1;
                    st_nxt.kind = SYM_DATA;
                    st_nxt.data = tok;
                    st_nxt.left = st_r.left - 5'h01;
                    st_nxt.valid = 1'b1;
                    st_nxt.tst = TX_EMIT;
                end
            TX_EMIT:
                if (sym_ready)
                begin
                    st_nxt.valid = 1'b0;
                    st_nxt.tst = (st_r.left != 5'h00) ? TX_PACK : TX_FETCH;
                end
            default:
                st_nxt.tst = TX_IDLE;
        endcase
        // Transmit queue storage
        if (push)
        begin
            st_nxt.mem[st_r.wp] = byte_in;
            st_nxt.wp = st_r.wp + AW'(1);
        end
        if (qpop)
            st_nxt.rp = st_r.rp + AW'(1);
        st_nxt.cnt = st_r.cnt + (AW+1)'(push) - (AW+1)'(qpop);
        // Event flags; a set in the clearing cycle wins
        lv_chg = st_r.lv_s ^ st_r.lv_d;
        st_nxt.full_d = full_any;
        set_vec[PDF_F_SUPPLY] = lv_chg[PDF_LV_SUPPLY];
        set_vec[PDF_F_ACTIVITY] = lv_chg[PDF_LV_ACT];
        set_vec[PDF_F_COMPARE] = lv_chg[PDF_LV_COMP];
        set_vec[PDF_F_CRC] = crc_checked;
        set_vec[PDF_F_ALERT] = full_any & ~st_r.full_d;
        set_vec[PDF_F_WAKE] = st_r.lv_s[PDF_LV_WAKE] & ~st_r.lv_d[PDF_LV_WAKE];
        set_vec[PDF_F_LEVEL] = |lv_chg[1:0];
        st_nxt.flags = (clr ? 8'h00 : st_r.flags) | set_vec;
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st_r <= '0;
            st_r.flags <= PDF_FLAGS_RST;
            st_r.oe_b <= 1'b1;
            st_r.scl_m <= 1'b1;
            st_r.scl_s <= 1'b1;
            st_r.scl_d <= 1'b1;
            st_r.sda_m <= 1'b1;
            st_r.sda_s <= 1'b1;
            st_r.sda_d <= 1'b1;
        end
        else
            st_r <= st_nxt;
    end

    assign sda_o = 1'b0;
    assign sda_oe_b = st_r.oe_b;
    assign rx_pop = st_r.pop;
    assign sym_kind = st_r.kind;
    assign sym_data = st_r.data;
    assign sym_valid = st_r.valid;
    assign tx_drive = st_r.drive;
    assign txq_full = (st_r.cnt == (AW+1)'(DEPTH));
    assign txq_empty = (st_r.cnt == '0);

    ////////////////////////////////////////////////////////////////////
    property p_supply;
        @(posedge mclk) disable iff (!rst_b)
        $changed(st_r.lv_s[PDF_LV_SUPPLY]) |=> st_r.flags[PDF_F_SUPPLY];
    endproperty
    a_supply: assert property (p_supply) else $error("supply flag not set");
    property p_activity;
        @(posedge mclk) disable iff (!rst_b)
        $changed(st_r.lv_s[PDF_LV_ACT]) |=> st_r.flags[PDF_F_ACTIVITY];
    endproperty
    a_activity: assert property (p_activity) else $error("activity flag not set");
    property p_crc;
        @(posedge mclk) disable iff (!rst_b)
        crc_checked |=> st_r.flags[PDF_F_CRC];
    endproperty
    a_crc: assert property (p_crc) else $error("checksum flag not set");
    property p_alert;
        @(posedge mclk) disable iff (!rst_b)
        $rose(txq_full || rx_full) |=> st_r.flags[PDF_F_ALERT];
    endproperty
    a_alert: assert property (p_alert) else $error("alert flag not set");
    property p_collide;
        @(posedge mclk) disable iff (!rst_b)
        (go && st_r.tst == TX_IDLE && st_r.lv_s[PDF_LV_ACT])
            |=> st_r.flags[PDF_F_COLLIDE] && st_r.tst == TX_IDLE && !tx_drive;
    endproperty
    a_collide: assert property (p_collide) else $error("collision not handled");
    property p_push;
        @(posedge mclk) disable iff (!rst_b)
        (push && !qpop) |=> st_r.cnt == $past(st_r.cnt) + (AW+1)'(1);
    endproperty
    a_push: assert property (p_push) else $error("push lost");
    property p_hold;
        @(posedge mclk) disable iff (!rst_b)
        (sym_valid && !sym_ready) |=> sym_valid && $stable(sym_kind) && $stable(sym_data);
    endproperty
    a_hold: assert property (p_hold) else $error("symbol changed while offered");
    property p_clear;
        @(posedge mclk) disable iff (!rst_b)
        (clr && set_vec == 8'h00) |=> st_r.flags == 8'h00;
    endproperty
    a_clear: assert property (p_clear) else $error("flags not cleared by read");
    property p_sticky;
        @(posedge mclk) disable iff (!rst_b)
        (!clr && st_r.flags[PDF_F_WAKE]) |=> st_r.flags[PDF_F_WAKE];
    endproperty
    a_sticky: assert property (p_sticky) else $error("wake flag dropped");
endmodule

`default_nettype wire

// >>> pdf_pkg.sv
// Shared constants and types for the PD event flag and token FIFO port block
package pdf_pkg;
    // Register offsets and flag register reset value
    localparam logic [7:0] PDF_REG_FLAGS = 8'h42;
    localparam logic [7:0] PDF_REG_FIFO = 8'h43;
    localparam logic [7:0] PDF_FLAGS_RST = 8'h00;
    // Event flag bit positions
    localparam int PDF_F_SUPPLY = 7;
    localparam int PDF_F_ACTIVITY = 6;
    localparam int PDF_F_COMPARE = 5;
    localparam int PDF_F_CRC = 4;
    localparam int PDF_F_ALERT = 3;
    localparam int PDF_F_WAKE = 2;
    localparam int PDF_F_COLLIDE = 1;
    localparam int PDF_F_LEVEL = 0;
    // Positions in the synchronised level vector
    localparam int PDF_LV_SUPPLY = 5;
    localparam int PDF_LV_ACT = 4;
    localparam int PDF_LV_COMP = 3;
    localparam int PDF_LV_WAKE = 2;
    // Transmit tokens
    localparam logic [7:0] PDF_TOK_GO = 8'ha1;
    localparam logic [7:0] PDF_TOK_SYNC1 = 8'h12;
    localparam logic [7:0] PDF_TOK_SYNC2 = 8'h13;
    localparam logic [7:0] PDF_TOK_SYNC3 = 8'h1b;
    localparam logic [7:0] PDF_TOK_RST1 = 8'h15;
    localparam logic [7:0] PDF_TOK_RST2 = 8'h16;
    localparam logic [7:0] PDF_TOK_EOP = 8'h14;
    localparam logic [7:0] PDF_TOK_CRC = 8'hff;
    localparam logic [7:0] PDF_TOK_OFF = 8'hfe;
    localparam logic [2:0] PDF_TOK_PACK_TAG = 3'h4;
    localparam logic [4:0] PDF_PACK_MIN = 5'h02;
    localparam logic [4:0] PDF_PACK_MAX = 5'h1e;
    // Arbitrary 7-bit bus address of this port
    localparam logic [6:0] PDF_BUS_ADDR = 7'h22;
    typedef enum logic [2:0] {
        I2C_IDLE, I2C_ADDR, I2C_ACK, I2C_WBYTE, I2C_RBYTE, I2C_RACK
    } pdf_i2c_e;
    typedef enum logic [1:0] {
        TX_IDLE, TX_FETCH, TX_PACK, TX_EMIT
    } pdf_tx_e;
    typedef enum logic [2:0] {
        SYM_SYNC1, SYM_SYNC2, SYM_SYNC3, SYM_RST1, SYM_RST2, SYM_DATA, SYM_CRC, SYM_EOP
    } pdf_sym_e;
endpackage

// >>> pdf_host.sv
// Two-wire bus host model that issues register transfers to the port
`timescale 1ns/1ps
`default_nettype none

module pdf_host (
    input wire logic mclk, // System clock
    input wire logic sda, // Resolved data line level
    output logic scl, // Serial clock, still between frames
    output logic sda_rel // High releases the data line
);
    initial
    begin
        scl = 1'b1;
        sda_rel = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Quarter of a 160 ns bit
    task automatic qw();
        repeat (4) @(posedge mclk);
    endtask

    // Start or repeated start: data falls while the clock is high
    task automatic start_c();
        sda_rel <= 1'b1;
        qw();
        scl <= 1'b1;
        qw();
        sda_rel <= 1'b0;
        qw();
        scl <= 1'b0;
        qw();
    endtask

    task automatic stop_c();
        sda_rel <= 1'b0;
        qw();
        scl <= 1'b1;
        qw();
        sda_rel <= 1'b1;
        qw();
    endtask

    // Data set while the clock is low, sampled in mid high phase
    task automatic bit_c(input logic b, output logic s);
        sda_rel <= b;
        qw();
        scl <= 1'b1;
        qw();
        s = sda;
        qw();
        scl <= 1'b0;
        qw();
    endtask

    // Eight bits MSB first, then the acknowledge bit
    task automatic byte_c(input logic [7:0] d, input logic mack, output logic [7:0] r,
        output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
        begin
            bit_c(d[i], s);
            r[i] = s;
        end
        bit_c(mack, s);
        ack = ~s;
    endtask
endmodule

`default_nettype wire

// >>> test_pdf_port.sv
// Self-checking bench for the event flags and token FIFO port
`timescale 1ns/1ps
`default_nettype none

module test_pdf_port;
    import pdf_pkg::*;

    logic mclk, rst_b, scl, sda_rel, sda_o, sda_oe_b, sda_line;
    logic vbus_ok, cc_activity, comp_high, wake_det, crc_checked, rx_full, rx_pop;
    logic [1:0] bc_lvl;
    logic [7:0] rx_data, sym_data;
    logic rx_empty, sym_valid, sym_ready, tx_drive, txq_full, txq_empty, drive_seen;
    pdf_sym_e sym_kind;
    logic [7:0] rx_mem [2] = '{8'h5a, 8'h3c};
    int rx_idx = 0;
    int n_pops = 0;
    int n_fail = 0;
    int total_checks = 0;
    int cyc = 0;
    logic [10:0] sym_q[$];

    // Open-drain line with pull-up
    assign sda_line = sda_rel & (sda_oe_b | sda_o);
    assign rx_data = rx_mem[rx_idx % 2];
    assign rx_empty = (rx_idx >= 2);

    pdf_host host (.mclk(mclk), .sda(sda_line), .scl(scl), .sda_rel(sda_rel));

    pdf_port #(.DEPTH(16)) dut (.mclk(mclk), .rst_b(rst_b), .scl(scl), .sda_i(sda_line),
        .sda_o(sda_o), .sda_oe_b(sda_oe_b), .vbus_ok(vbus_ok), .cc_activity(cc_activity),
        .comp_high(comp_high), .wake_det(wake_det), .bc_lvl(bc_lvl),
        .crc_checked(crc_checked), .rx_data(rx_data), .rx_empty(rx_empty),
        .rx_full(rx_full), .rx_pop(rx_pop), .sym_kind(sym_kind), .sym_data(sym_data),
        .sym_valid(sym_valid), .sym_ready(sym_ready), .tx_drive(tx_drive),
        .txq_full(txq_full), .txq_empty(txq_empty));

    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Receive queue and stalling symbol sink
    always @(posedge mclk)
    begin
        cyc <= cyc + 1;
        sym_ready <= ~sym_ready;
        if (rx_pop === 1'b1)
        begin
            rx_idx <= rx_idx + 1;
            n_pops <= n_pops + 1;
        end
        if (sym_valid === 1'b1 && sym_ready === 1'b1)
            sym_q.push_back({sym_kind, sym_data});
        if (tx_drive === 1'b1)
            drive_seen <= 1'b1;
        if (cyc == 60000)
        begin
            n_fail++;
            summarize();
        end
    end

    task automatic check(string nm, logic [7:0] seen, logic [7:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wr(logic [7:0] ptr, logic [7:0] d[$]);
        logic [7:0] r;
        logic a;
        host.start_c();
        host.byte_c({PDF_BUS_ADDR, 1'b0}, 1'b1, r, a);
        check("addr_ack", {7'h0, a}, 8'h01);
        host.byte_c(ptr, 1'b1, r, a);
        foreach (d[i]) host.byte_c(d[i], 1'b1, r, a);
        host.stop_c();
    endtask

    task automatic rd(logic [7:0] ptr, int n, output logic [7:0] q[$]);
        logic [7:0] r;
        logic a;
        q = {};
        host.start_c();
        host.byte_c({PDF_BUS_ADDR, 1'b0}, 1'b1, r, a);
        host.byte_c(ptr, 1'b1, r, a);
        host.start_c();
        host.byte_c({PDF_BUS_ADDR, 1'b1}, 1'b1, r, a);
        for (int i = 0; i < n; i++)
        begin
            host.byte_c(8'hff, i == n - 1, r, a);
            q.push_back(r);
        end
        host.stop_c();
    endtask

    // Read flags twice: event bits first, all clear after
    task automatic ev_check(string nm, logic [7:0] exp);
        logic [7:0] r[$];
        repeat (6) @(posedge mclk);
        rd(PDF_REG_FLAGS, 1, r);
        check(nm, r[0], exp);
        rd(PDF_REG_FLAGS, 1, r);
        check(nm, r[0], 8'h00);
    endtask

    task automatic wait_idle();
        int i;
        for (i = 0; i < 3000 && (tx_drive !== 1'b0 || txq_empty !== 1'b1); i++)
            @(posedge mclk);
        check("tx_idle", {7'h0, tx_drive}, 8'h00);
        check("txq_drained", {7'h0, txq_empty}, 8'h01);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_events();
        ev_check("flags_reset", 8'h00);
        vbus_ok <= 1'b1;
        ev_check("supply_up", 8'h80);
        vbus_ok <= 1'b0;
        ev_check("supply_down", 8'h80);
        comp_high <= 1'b1;
        ev_check("compare", 8'h20);
        crc_checked <= 1'b1;
        @(posedge mclk);
        crc_checked <= 1'b0;
        ev_check("crc_ready", 8'h10);
        rx_full <= 1'b1;
        ev_check("rx_alert", 8'h08);
        rx_full <= 1'b0;
        wake_det <= 1'b1;
        ev_check("wake", 8'h04);
        bc_lvl <= 2'h2;
        ev_check("level", 8'h01);
    endtask

    // Every transmit token in one contiguous write, start command last
    task automatic t_tx();
        pdf_sym_e ek[$] = '{SYM_SYNC1, SYM_SYNC2, SYM_SYNC3, SYM_RST1, SYM_RST2,
            SYM_DATA, SYM_DATA, SYM_CRC, SYM_EOP};
        sym_q = {};
        drive_seen <= 1'b0;
        wr(PDF_REG_FIFO, '{8'h12, 8'h13, 8'h1b, 8'h15, 8'h16, 8'h82, 8'h5a, 8'hc3,
            8'h81, 8'hff, 8'h14, 8'hfe, 8'ha1});
        wait_idle();
        check("drive_seen", {7'h0, drive_seen}, 8'h01);
        check("sym_count", 8'(sym_q.size()), 8'd9);
        foreach (ek[i]) check("sym_kind", {5'h0, sym_q[i][10:8]}, {5'h0, ek[i]});
        check("pack_a", sym_q[5][7:0], 8'h5a);
        check("pack_b", sym_q[6][7:0], 8'hc3);
    endtask

    // One token past full is dropped; queue drains while the sink stalls
    task automatic t_fill();
        logic [7:0] d[$];
        repeat (17) d.push_back(PDF_TOK_EOP);
        sym_q = {};
        wr(PDF_REG_FIFO, d);
        check("txq_full", {7'h0, txq_full}, 8'h01);
        ev_check("tx_alert", 8'h08);
        wr(PDF_REG_FIFO, '{PDF_TOK_GO});
        wait_idle();
        check("drain_count", 8'(sym_q.size()), 8'd16);
    endtask

    task automatic t_rx();
        logic [7:0] r[$];
        rd(PDF_REG_FIFO, 2, r);
        check("rx_first", r[0], 8'h5a);
        check("rx_second", r[1], 8'h3c);
        check("rx_pops", 8'(n_pops), 8'd2);
        rd(8'h10, 1, r);
        check("unmapped", r[0], 8'h00);
    endtask

    task automatic t_collide();
        logic [7:0] r[$];
        cc_activity <= 1'b1;
        ev_check("activity_on", 8'h40);
        sym_q = {};
        drive_seen <= 1'b0;
        wr(PDF_REG_FIFO, '{PDF_TOK_EOP, PDF_TOK_GO});
        repeat (20) @(posedge mclk);
        ev_check("collision", 8'h02);
        rd(PDF_REG_FIFO, 1, r);
        check("rx_after_collide", r[0], 8'h5a);
        check("rx_no_pop", 8'(n_pops), 8'd2);
        check("no_syms", 8'(sym_q.size()), 8'd0);
        check("no_drive", {7'h0, drive_seen}, 8'h00);
        cc_activity <= 1'b0;
        ev_check("activity_off", 8'h40);
        // Driver-off token stops the engine with a token still queued
        sym_q = {};
        wr(PDF_REG_FIFO, '{PDF_TOK_OFF, PDF_TOK_EOP, PDF_TOK_GO});
        repeat (40) @(posedge mclk);
        check("off_syms", 8'(sym_q.size()), 8'd1);
        check("off_drive", {7'h0, tx_drive}, 8'h00);
        check("off_left", {7'h0, txq_empty}, 8'h00);
    endtask

    task automatic summarize();
        $display("checks %0d failures %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial
    begin
        rst_b = 1'b0;
        vbus_ok = 1'b0;
        cc_activity = 1'b0;
        comp_high = 1'b0;
        wake_det = 1'b0;
        bc_lvl = 2'h0;
        crc_checked = 1'b0;
        rx_full = 1'b0;
        sym_ready = 1'b0;
        drive_seen = 1'b0;
        repeat (20) @(posedge mclk);
        rst_b <= 1'b1;
        repeat (4) @(posedge mclk);
        check("txq_empty_rst", {7'h0, txq_empty}, 8'h01);
        t_events();
        t_tx();
        t_fill();
        t_rx();
        t_collide();
        summarize();
    end
endmodule

`default_nettype wire
